// File: rtl/usf_evt_if.sv
/*
  Interface carrying receive events from the receive-side module to the top.
  Assumes both ends share the module clock.
*/
`default_nettype none
interface usf_evt_if;
  logic rx_load;
  logic ovr;
  logic frm;
  logic par;
  logic rx_char_ready;
  modport src (output rx_load, output ovr, output frm, output par, output rx_char_ready);
  modport dst (input rx_load, input ovr, input frm, input par, input rx_char_ready);
endinterface
`default_nettype wire

// File: rtl/usf_pkg.sv
/*
  Package for the serial status-flag block: register offsets, status bit
  positions, mode and command bit positions, reset values and counts.
  Assumes a 32-bit register port with byte addresses and a single clock.
*/
`default_nettype none
package usf_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [31:0] USF_STATUS_OFS = 32'h400e0814;
  localparam logic [31:0] USF_MODE_OFS = 32'h400e0800;
  localparam logic [31:0] USF_CMD_OFS = 32'h400e0804;
  localparam logic [31:0] USF_IMASK_OFS = 32'h400e0808;
  localparam logic [31:0] USF_IFLAG_OFS = 32'h400e080c;
  localparam logic [31:0] USF_RXHOLD_OFS = 32'h400e0818;
  localparam logic [31:0] USF_TXHOLD_OFS = 32'h400e081c;
  localparam int USF_NREG = 6;
  // ----------------------------------------------------------------
  // status bit positions
  // ----------------------------------------------------------------
  localparam int USF_B_RXAVAIL = 0;
  localparam int USF_B_TXFREE = 1;
  localparam int USF_B_RXEND = 3;
  localparam int USF_B_TXEND = 4;
  localparam int USF_B_OVR = 5;
  localparam int USF_B_FRM = 6;
  localparam int USF_B_PAR = 7;
  localparam int USF_B_TXIDLE = 9;
  // mode bits
  localparam int USF_M_RXEN = 0;
  localparam int USF_M_TXEN = 1;
  // command bits
  localparam int USF_C_CLRSTA = 0;
  // ----------------------------------------------------------------
  // reset values and counts
  // ----------------------------------------------------------------
  localparam logic [31:0] USF_ZERO_WORD = 32'h0000_0000;
  localparam logic [1:0] USF_MODE_RST = 2'h0;
  localparam logic [9:0] USF_MASK_RST = 10'h000;
  localparam logic [9:0] USF_EVT_MASK = 10'h2fb;
  localparam logic [3:0] USF_SHIFT_CYCLES = 4'ha;
endpackage
`default_nettype wire

// File: rtl/usf_rx_side.sv
/*
  Receive holding logic: tracks a complete character waiting for software,
  raises overrun when one arrives before the last was read.
  Assumes character strobes are one cycle and synchronous to mclk_i.
*/
`default_nettype none
module usf_rx_side
  import usf_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic rx_en_i,
  input wire logic char_valid_i,
  input wire logic char_frame_err_i,
  input wire logic char_parity_err_i,
  input wire logic rhr_read_i,
  usf_evt_if.src evt
);
  typedef struct packed {
    logic full;
  } usf_rx_state_t;
  usf_rx_state_t state_reg, state_next;

  always_comb begin
    state_next = state_reg;
    if (!rx_en_i) begin
      state_next.full = 1'b0;
    end else if (char_valid_i) begin
      state_next.full = 1'b1;
    end else if (rhr_read_i) begin
      state_next.full = 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // a read in the same cycle as a new character still overruns only if unread
  assign evt.rx_load = rx_en_i & char_valid_i;
  assign evt.ovr = rx_en_i & char_valid_i & state_reg.full & ~rhr_read_i;
  assign evt.frm = rx_en_i & char_valid_i & char_frame_err_i;
  assign evt.par = rx_en_i & char_valid_i & char_parity_err_i;
  assign evt.rx_char_ready = state_reg.full;
endmodule
`default_nettype wire

// File: rtl/usf_status.sv
/*
  Serial status-flag block top: status word, sticky error flags, mode,
  command, interrupt mask/flag registers and a plain register port.
  Words: mode (receive and transmit enables), command (status clear),
  interrupt mask, interrupt flags, status (read-only), receive holding
  (read-only) and transmit holding (write-only). Reads answer one cycle
  after the strobe and return zero otherwise.
  Assumes one 20 MHz clock and synchronous strobe inputs.
*/
`default_nettype none
// What this block does
// - receive-ready reads 1 while an unread complete character sits in holding register
// - receive-ready reads 0 after the holding register read or with receiver off
// - transmit-ready reads 0 while a written character waits or transmitter off
// - transmit-ready reads 1 when the transmitter is on and no written character waits for the shifter
// - receive DMA end bit follows the receive channel end signal one clock later
// - transmit DMA end bit follows the transmit channel end signal one clock later
// - overrun flag sets on any overrun and holds until clear-status command
// - framing flag sets on any framing error and holds until clear-status command
// - parity flag sets on any parity error and holds until clear-status command
// - transmitter-empty reads 1 only with holding register empty and shifter idle
// - transmitter-empty reads 0 while holding full, shifter busy or transmitter off
module usf_status
  import usf_pkg::*;
#(
  parameter int BAUD_DIV = 16
)
(
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic [31:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic char_valid_i,
  input wire logic [7:0] char_data_i,
  input wire logic char_frame_err_i,
  input wire logic char_parity_err_i,
  input wire logic rx_dma_end_i,
  input wire logic tx_dma_end_i,
  output logic [7:0] tx_char_o,
  output logic tx_char_load_o,
  output logic irq_o
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] mode;
    logic [9:0] mask;
    logic [9:0] iflag;
    logic ovr;
    logic frm;
    logic par;
    logic rx_end;
    logic tx_end;
    logic [7:0] rx_data;
    logic [7:0] tx_data;
    logic tx_load;
    logic [15:0] div;
    logic [31:0] rdata;
    logic irq;
  } usf_state_t;
  usf_state_t state_reg, state_next;

  usf_evt_if evt ();
  logic hold_full;
  logic shift_busy;
  logic bit_tick;
  logic rhr_read;
  logic thr_write;
  logic [9:0] status_bits;
  logic [31:0] status_word;

  assign rhr_read = rd_i && (addr_i == USF_RXHOLD_OFS);
  assign thr_write = wr_i && (addr_i == USF_TXHOLD_OFS) && state_reg.mode[USF_M_TXEN];
  assign bit_tick = (state_reg.div == 16'h0000);

  usf_rx_side u_rx (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .rx_en_i(state_reg.mode[USF_M_RXEN]),
    .char_valid_i(char_valid_i),
    .char_frame_err_i(char_frame_err_i),
    .char_parity_err_i(char_parity_err_i),
    .rhr_read_i(rhr_read),
    .evt(evt)
  );

  usf_tx_side u_tx (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .tx_en_i(state_reg.mode[USF_M_TXEN]),
    .thr_write_i(thr_write),
    .bit_tick_i(bit_tick),
    .hold_full_o(hold_full),
    .shift_busy_o(shift_busy)
  );

  // ----------------------------------------------------------------
  // status word assembly
  // ----------------------------------------------------------------
  always_comb begin
    status_bits = '0;
    status_bits[USF_B_RXAVAIL] = evt.rx_char_ready;
    status_bits[USF_B_TXFREE] = state_reg.mode[USF_M_TXEN] & ~hold_full;
    status_bits[USF_B_RXEND] = state_reg.rx_end;
    status_bits[USF_B_TXEND] = state_reg.tx_end;
    status_bits[USF_B_OVR] = state_reg.ovr;
    status_bits[USF_B_FRM] = state_reg.frm;
    status_bits[USF_B_PAR] = state_reg.par;
    // both stages must drain before the line counts as idle
    status_bits[USF_B_TXIDLE] = state_reg.mode[USF_M_TXEN] & ~hold_full & ~shift_busy;
    status_word = {22'h000000, status_bits};
  end

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  logic sel_status;
  logic sel_mode;
  logic sel_cmd;
  logic sel_imask;
  logic sel_iflag;
  logic sel_rxhold;
  logic mode_write;
  logic mask_write;
  logic cmd_clear;

  // status, receive holding and unmapped words have no write select, so writes there fall away
  assign sel_status = (addr_i == USF_STATUS_OFS);
  assign sel_mode = (addr_i == USF_MODE_OFS);
  assign sel_cmd = (addr_i == USF_CMD_OFS);
  assign sel_imask = (addr_i == USF_IMASK_OFS);
  assign sel_iflag = (addr_i == USF_IFLAG_OFS);
  assign sel_rxhold = (addr_i == USF_RXHOLD_OFS);
  assign mode_write = wr_i & sel_mode;
  assign mask_write = wr_i & sel_imask;
  // only the clear bit of the command word acts; the rest is reserved
  assign cmd_clear = wr_i & sel_cmd & wdata_i[USF_C_CLRSTA];

  // ----------------------------------------------------------------
  // baud tick divider
  // ----------------------------------------------------------------
  logic [15:0] div_next;

  always_comb begin
    if (bit_tick) begin
      div_next = 16'(BAUD_DIV - 1);
    end else begin
      div_next = state_reg.div - 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // sticky error flags
  // ----------------------------------------------------------------
  logic [2:0] err_event;
  logic [2:0] err_held;
  logic [2:0] err_next;

  assign err_event = {evt.par, evt.frm, evt.ovr};
  assign err_held = {state_reg.par, state_reg.frm, state_reg.ovr};

  // the set wins over a same-cycle clear so no error slips past software
  for (genvar ge = 0; ge < 3; ge++) begin : g_sticky
    assign err_next[ge] = err_event[ge] | (err_held[ge] & ~cmd_clear);
  end

  // ----------------------------------------------------------------
  // interrupt flags
  // ----------------------------------------------------------------
  logic [9:0] iflag_next;

  // level-fed: a flag cleared while its status bit stays high comes back at once
  for (genvar gi = 0; gi < 10; gi++) begin : g_iflag
    logic flag_set;
    logic flag_clr;
    assign flag_set = status_bits[gi] & USF_EVT_MASK[gi];
    assign flag_clr = wr_i & sel_iflag & wdata_i[gi];
    assign iflag_next[gi] = flag_set | (state_reg.iflag[gi] & ~flag_clr);
  end

  // ----------------------------------------------------------------
  // read data selection
  // ----------------------------------------------------------------
  logic [31:0] read_word;

  always_comb begin
    read_word = USF_ZERO_WORD;
    if (sel_status) begin
      read_word = status_word;
    end else if (sel_mode) begin
      read_word = {30'h00000000, state_reg.mode};
    end else if (sel_imask) begin
      read_word = {22'h000000, state_reg.mask};
    end else if (sel_iflag) begin
      read_word = {22'h000000, state_reg.iflag};
    end else if (sel_rxhold) begin
      read_word = {24'h000000, state_reg.rx_data};
    end
  end

  // ----------------------------------------------------------------
  // mode, mask and interrupt output
  // ----------------------------------------------------------------
  logic [1:0] mode_next;
  logic [9:0] mask_next;
  logic [9:0] irq_pending;

  // enables change only at the edge, so both sides see one mode per cycle
  assign mode_next = mode_write ? wdata_i[1:0] : state_reg.mode;
  assign mask_next = mask_write ? wdata_i[9:0] : state_reg.mask;
  assign irq_pending = iflag_next & mask_next;

  // ----------------------------------------------------------------
  // data capture
  // ----------------------------------------------------------------
  logic [7:0] rx_data_next;
  logic [7:0] tx_data_next;

  // an overrunning byte still replaces the old one: the newest character wins
  assign rx_data_next = evt.rx_load ? char_data_i : state_reg.rx_data;
  assign tx_data_next = thr_write ? wdata_i[7:0] : state_reg.tx_data;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.mode = mode_next;
    state_next.mask = mask_next;
    state_next.iflag = iflag_next;
    state_next.ovr = err_next[0];
    state_next.frm = err_next[1];
    state_next.par = err_next[2];
    state_next.rx_end = rx_dma_end_i;
    state_next.tx_end = tx_dma_end_i;
    state_next.rx_data = rx_data_next;
    state_next.tx_data = tx_data_next;
    state_next.tx_load = thr_write;
    state_next.div = div_next;
    state_next.rdata = USF_ZERO_WORD;
    if (rd_i) begin
      state_next.rdata = read_word;
    end
    state_next.irq = |irq_pending;
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign rdata_o = state_reg.rdata;
  assign tx_char_o = state_reg.tx_data;
  assign tx_char_load_o = state_reg.tx_load;
  assign irq_o = state_reg.irq;
endmodule
`default_nettype wire

// File: rtl/usf_tx_side.sv
/*
  Transmit holding and shifter occupancy model: a written character waits
  in the holding slot, moves to the shifter, which stays busy a fixed count.
  Assumes writes are one-cycle strobes synchronous to mclk_i.
*/
`default_nettype none
module usf_tx_side
  import usf_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic tx_en_i,
  input wire logic thr_write_i,
  input wire logic bit_tick_i,
  output logic hold_full_o,
  output logic shift_busy_o
);
  typedef struct packed {
    logic hold;
    logic busy;
    logic [3:0] cnt;
  } usf_tx_state_t;
  usf_tx_state_t state_reg, state_next;

  always_comb begin
    state_next = state_reg;
    if (!tx_en_i) begin
      state_next = '0;
    end else begin
      if (state_reg.busy && bit_tick_i) begin
        if (state_reg.cnt == 4'h1) begin
          state_next.busy = 1'b0;
        end
        state_next.cnt = state_reg.cnt - 4'h1;
      end
      if (state_reg.hold && !state_next.busy) begin
        state_next.hold = 1'b0;
        state_next.busy = 1'b1;
        state_next.cnt = USF_SHIFT_CYCLES;
      end
      if (thr_write_i) begin
        state_next.hold = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign hold_full_o = state_reg.hold;
  assign shift_busy_o = state_reg.busy;
endmodule
`default_nettype wire

// File: testbench/testbench.sv
/* self-checking bench for the status-flag block with the remote partner.
   assumes a shortened baud divider of 2 and the register map of the package. */
`default_nettype none
module testbench
  import usf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_i, reset_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, rxe = 1'b0, txe = 1'b0;
  logic [31:0] addr_i = 32'h0, wdata_i = 32'h0, rdata_o, d;
  logic cv, fe, pe, ld, irq_o;
  logic [7:0] cd, tc;
  int num_errors = 0, num_checks = 0;
  usf_status #(.BAUD_DIV(2)) i_dut (.mclk_i, .reset_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .char_valid_i(cv), .char_data_i(cd), .char_frame_err_i(fe), .char_parity_err_i(pe),
    .rx_dma_end_i(rxe), .tx_dma_end_i(txe), .tx_char_o(tc), .tx_char_load_o(ld), .irq_o);
  usf_remote_peer peer (.mclk_i, .tx_char_i(tc), .tx_load_i(ld), .char_valid_o(cv), .char_data_o(cd),
    .frame_err_o(fe), .parity_err_o(pe));
  initial begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    @(posedge mclk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= v;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask
  // n back-to-back reads of one address, last answer kept
  task automatic rd(input logic [31:0] a, input int n, output logic [31:0] v);
    @(posedge mclk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    repeat (n) @(posedge mclk_i);
    rd_i <= 1'b0;
    // the answer stands one cycle and is taken at the edge that closes it
    @(posedge mclk_i);
    v = rdata_o;
  endtask
  task automatic t_regs();
    rd(USF_STATUS_OFS, 1, d); chk(d, 32'h0);
    wr(USF_STATUS_OFS, 32'hffffffff);
    rd(USF_STATUS_OFS, 1, d); chk(d, 32'h0);
    rd(32'h400e0810, 1, d); chk(d, 32'h0);
    $display("test regs done");
  endtask
  task automatic t_tx();
    wr(USF_MODE_OFS, 32'h3);
    rd(USF_STATUS_OFS, 1, d); chk(d, 32'h202);
    wr(USF_TXHOLD_OFS, 32'h5a);
    wr(USF_TXHOLD_OFS, 32'ha5);
    rd(USF_STATUS_OFS, 1, d); chk(d, 32'h0);
    repeat (60) @(posedge mclk_i);
    rd(USF_STATUS_OFS, 1, d); chk(d, 32'h202);
    chk(peer.loads, 2);
    chk({24'h0, peer.last_tx}, 32'ha5);
    wr(USF_MODE_OFS, 32'h1);
    rd(USF_STATUS_OFS, 1, d); chk(d, 32'h0);
    $display("test tx done");
  endtask
  task automatic t_rx();
    wr(USF_MODE_OFS, 32'h3);
    peer.send(8'hc3, 1'b0, 1'b0);
    rd(USF_STATUS_OFS, 1, d); chk(d, 32'h203);
    rd(USF_RXHOLD_OFS, 1, d); chk(d, 32'hc3);
    rd(USF_STATUS_OFS, 1, d); chk(d, 32'h202);
    peer.send(8'h11, 1'b1, 1'b0);
    peer.send(8'h22, 1'b0, 1'b1);
    rd(USF_STATUS_OFS, 2, d); chk(d, 32'h2e3);
    chk({31'h0, irq_o}, 32'h0);
    wr(USF_IMASK_OFS, 32'h20);
    repeat (2) @(posedge mclk_i);
    #1 chk({31'h0, irq_o}, 32'h1);
    rd(USF_RXHOLD_OFS, 1, d); chk(d, 32'h22);
    wr(USF_CMD_OFS, 32'h1);
    rd(USF_STATUS_OFS, 1, d); chk(d, 32'h202);
    wr(USF_IFLAG_OFS, 32'h20);
    repeat (2) @(posedge mclk_i);
    #1 chk({31'h0, irq_o}, 32'h0);
    peer.send(8'h44, 1'b0, 1'b0);
    wr(USF_MODE_OFS, 32'h2);
    rd(USF_STATUS_OFS, 1, d); chk(d, 32'h202);
    $display("test rx done");
  endtask
  task automatic t_dma();
    @(posedge mclk_i);
    rxe <= 1'b1;
    rd(USF_STATUS_OFS, 1, d); chk(d, 32'h20a);
    rxe <= 1'b0;
    txe <= 1'b1;
    rd(USF_STATUS_OFS, 1, d); chk(d, 32'h212);
    txe <= 1'b0;
    rd(USF_STATUS_OFS, 1, d); chk(d, 32'h202);
    $display("test dma done");
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    t_regs();
    t_tx();
    t_rx();
    t_dma();
    final_report();
  end
  // tests need well under a thousand cycles
  initial begin
    #(50 * 5000);
    num_errors++;
    final_report();
  end
endmodule
`default_nettype wire

// File: testbench/usf_remote_peer.sv
/* remote serial partner: hands complete characters in, counts sent ones.
   assumes the testbench calls send at or after a clock edge. */
`default_nettype none
module usf_remote_peer (
  input wire logic mclk_i,
  input wire logic [7:0] tx_char_i,
  input wire logic tx_load_i,
  output logic char_valid_o,
  output logic [7:0] char_data_o,
  output logic frame_err_o,
  output logic parity_err_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int loads = 0;
  logic [7:0] last_tx = 8'h00;
  initial begin
    char_valid_o = 1'b0;
    char_data_o = 8'h00;
    frame_err_o = 1'b0;
    parity_err_o = 1'b0;
  end
  always @(posedge mclk_i) begin
    if (tx_load_i) begin
      loads <= loads + 1;
      last_tx <= tx_char_i;
    end
  end
  task automatic send(input logic [7:0] d, input logic fe, input logic pe);
    @(posedge mclk_i);
    char_valid_o <= 1'b1;
    char_data_o <= d;
    frame_err_o <= fe;
    parity_err_o <= pe;
    @(posedge mclk_i);
    char_valid_o <= 1'b0;
    // stale lines flip so nothing can lean on held values
    char_data_o <= ~d;
    frame_err_o <= ~fe;
    parity_err_o <= ~pe;
  endtask
endmodule
`default_nettype wire

// File: testbench/usf_status_properties.sv
/* checker for the status-flag block top, bound to every instance.
   assumes strobes keep the one-cycle register port contract. */
`default_nettype none
module usf_status_properties
  import usf_pkg::*;
#(
  parameter int BAUD_DIV = 16
)
(
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic [31:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic char_valid_i,
  input wire logic [7:0] char_data_i,
  input wire logic char_frame_err_i,
  input wire logic char_parity_err_i,
  input wire logic rx_dma_end_i,
  input wire logic tx_dma_end_i,
  input wire logic [7:0] tx_char_o,
  input wire logic tx_char_load_o,
  input wire logic irq_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  sequence stat_rd;
    rd_i && addr_i == USF_STATUS_OFS;
  endsequence
  sequence hold_rd;
    rd_i && addr_i == USF_RXHOLD_OFS && !char_valid_i;
  endsequence
  rd_quiet_a: assert property (!rd_i |=> rdata_o == USF_ZERO_WORD) else $error("read data not zero");
  rx_end_a: assert property (stat_rd |=> rdata_o[USF_B_RXEND] == $past(rx_dma_end_i, 2))
    else $error("rx dma end bit wrong");
  tx_end_a: assert property (stat_rd |=> rdata_o[USF_B_TXEND] == $past(tx_dma_end_i, 2))
    else $error("tx dma end bit wrong");
  reserved_zero_a: assert property (stat_rd |=> (rdata_o & 32'hfffffd04) == 32'h0)
    else $error("reserved status bit set");
  unmapped_zero_a: assert property (rd_i && addr_i == 32'h400e0810 |=> rdata_o == 32'h0)
    else $error("unmapped read not zero");
  idle_needs_free_a: assert property (stat_rd ##1 rdata_o[USF_B_TXIDLE] |-> rdata_o[USF_B_TXFREE])
    else $error("tx idle without holding free");
  rx_ready_clear_a: assert property (hold_rd ##1 !char_valid_i ##1 stat_rd |=> !rdata_o[USF_B_RXAVAIL])
    else $error("rx ready after holding read");
  errors_sticky_a: assert property (stat_rd ##1 stat_rd |=>
    (rdata_o[7:5] & $past(rdata_o[7:5])) == $past(rdata_o[7:5])) else $error("error flag dropped");
  tx_load_a: assert property (tx_char_load_o |-> $past(wr_i) && $past(addr_i) == USF_TXHOLD_OFS
    && tx_char_o == $past(wdata_i[7:0])) else $error("tx load without write");
endmodule
bind usf_status usf_status_properties #(.BAUD_DIV(BAUD_DIV)) i_props (.mclk_i, .reset_n_i, .addr_i,
  .wdata_i, .wr_i, .rd_i, .rdata_o, .char_valid_i, .char_data_i, .char_frame_err_i, .char_parity_err_i,
  .rx_dma_end_i, .tx_dma_end_i, .tx_char_o, .tx_char_load_o, .irq_o);
`default_nettype wire
